// ---- ps_cfg_device.sv ----
// Purpose: device end of the passive serial configuration port
// Assumes: frame of FRAME_BYTES bytes, first the sync byte, last an xor check byte
// Notes: link logic runs on the serial clock; bytes cross to clk_sys by toggle handshake
// Summary of operation
// - host raises request; device then releases fault
// - host sends bits LSB first per byte
// - host clocks until load complete rises
// - capture each bit on serial clock rise
// - whole frame received: raise load complete, initialize
// - serial clocks ignored after configuration completes
// - host serial clock at most 100 MHz
// - clock may pause; state is kept
// - configuration error drives fault low
// - host retries with low request pulse
// - request low pulse at least 40 us
// - auto-retry releases fault after time-out
// - host checks completion, reconfigures otherwise
// - fault held low about 100 ms at power-up
// - load complete low until configured
// - request low drops fault and load complete
// - fault released soon; low 10 to 40 us
// - first serial edge 40 us after request
// - user mode 20 us or 140 user clocks
// - user clock: request low 270 periods
// - host parks data and clock after configuration
// - retry time-out 30 us, else held low
`timescale 1ns/1ps
`default_nettype none
`include "ps_cfg_regs.svh"
module ps_cfg_device
  import ps_cfg_pkg::*;
#(
  parameter int FRAME_BYTES = `PS_FRAME_BYTES,
  parameter int POWERUP_CYCLES = `PS_POWERUP_CYC
) (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // configuration pins
  ps_cfg_if.device link,
  // options, same clock domain
  input wire logic autoRetry,
  input wire logic useUserClk,
  // optional initialization clock, asynchronous
  input wire logic userInitClk,
  // payload bytes and user mode to device logic
  output logic [7:0] cfgByte,
  output logic cfgByteValid,
  output logic userMode
);
  localparam cnt_t POWERUP_C = cnt_t'(POWERUP_CYCLES);
  localparam cnt_t STATUS_MIN_C = cnt_t'(`PS_STATUS_MIN_CYC);
  localparam cnt_t RETRY_C = cnt_t'(`PS_RETRY_CYC);
  localparam cnt_t INIT_C = cnt_t'(`PS_INIT_CYC);
  localparam cnt_t USER_INIT_C = cnt_t'(`PS_USER_INIT_PERIODS);
  localparam logic [15:0] LAST_IDX = 16'(FRAME_BYTES - 1);
  localparam logic [7:0] SYNC_B = `PS_SYNC_BYTE;

  dev_sys_t s_ff, nxt_s;
  dev_link_t l_ff, nxt_l;
  logic linkRst_n;
  logic byteEv;
  logic [7:0] inByte;

  // link side held in reset unless a load is armed, so stray serial clocks
  // before or after configuration do nothing; release happens while the host
  // still keeps the serial clock idle, so there is no recovery race
  assign linkRst_n = arst_n & s_ff.armed;

  always_comb begin
    nxt_l = l_ff;
    nxt_l.shift = {link.serialCfgBit, l_ff.shift[7:1]};
    nxt_l.bitCnt = l_ff.bitCnt + 3'h1;
    if (l_ff.bitCnt == 3'h7) begin
      // lsb arrives first, so after eight bits it sits in bit 0
      nxt_l.byteData = {link.serialCfgBit, l_ff.shift[7:1]};
      nxt_l.byteTgl = ~l_ff.byteTgl;
    end
  end

  // a stopped serial clock simply freezes this state
  always_ff @(posedge link.serialCfgClk or negedge linkRst_n) begin
    if (!linkRst_n) begin
      l_ff <= '0;
    end else begin
      l_ff <= nxt_l;
    end
  end

  // byteData is stable for seven serial clocks after the toggle moves
  assign byteEv = s_ff.tglS2 != s_ff.tglSeen;
  assign inByte = l_ff.byteData;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.reqS1 = link.reconfigRequest_n;
    nxt_s.reqS2 = s_ff.reqS1;
    nxt_s.tglS1 = l_ff.byteTgl;
    nxt_s.tglS2 = s_ff.tglS1;
    nxt_s.tglSeen = s_ff.tglS2;
    nxt_s.uclkS1 = userInitClk;
    nxt_s.uclkS2 = s_ff.uclkS1;
    nxt_s.uclkPrev = s_ff.uclkS2;
    nxt_s.outValid = 1'b0;
    if (s_ff.cnt != '1) begin
      nxt_s.cnt = s_ff.cnt + cnt_t'(1);
    end
    case (s_ff.state)
      ST_POWERUP: begin
        nxt_s.faultOe_n = 1'b0;
        if (s_ff.cnt >= POWERUP_C - cnt_t'(1)) begin
          nxt_s.state = s_ff.reqS2 ? ST_RELEASE : ST_RESET;
        end
      end
      ST_RESET: begin
        if (s_ff.reqS2) begin
          nxt_s.state = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        // fault low for at least the minimum width, then released at once
        if (s_ff.cnt >= STATUS_MIN_C - cnt_t'(1)) begin
          nxt_s.faultOe_n = 1'b1;
          nxt_s.state = ST_LOAD;
          nxt_s.armed = 1'b1;
          nxt_s.byteCnt = '0;
          nxt_s.chk = '0;
        end
      end
      ST_LOAD: begin
        if (byteEv) begin
          nxt_s.byteCnt = s_ff.byteCnt + 16'h1;
          nxt_s.chk = s_ff.chk ^ inByte;
          if ((s_ff.byteCnt == 16'h0 && inByte != SYNC_B) ||
              (s_ff.byteCnt == LAST_IDX && inByte != s_ff.chk)) begin
            nxt_s.state = ST_ERROR;
            nxt_s.faultOe_n = 1'b0;
            nxt_s.armed = 1'b0;
            nxt_s.cnt = '0;
          end else if (s_ff.byteCnt == LAST_IDX) begin
            nxt_s.state = ST_INIT;
            nxt_s.loadDone = 1'b1;
            nxt_s.armed = 1'b0;
            nxt_s.cnt = '0;
          end else if (s_ff.byteCnt != 16'h0) begin
            nxt_s.outByte = inByte;
            nxt_s.outValid = 1'b1;
          end
        end
      end
      ST_ERROR: begin
        // without auto-retry only a low request pulse leaves this state
        if (autoRetry && s_ff.cnt >= RETRY_C - cnt_t'(1)) begin
          nxt_s.faultOe_n = 1'b1;
          nxt_s.state = ST_LOAD;
          nxt_s.armed = 1'b1;
          nxt_s.byteCnt = '0;
          nxt_s.chk = '0;
        end
      end
      ST_INIT: begin
        if (useUserClk) begin
          if (s_ff.uclkS2 && !s_ff.uclkPrev) begin
            if (s_ff.byteCnt >= 16'(USER_INIT_C) - 16'h1) begin
              nxt_s.state = ST_USER;
              nxt_s.initDone = 1'b1;
            end else begin
              nxt_s.byteCnt = s_ff.byteCnt + 16'h1;
            end
          end
        end else if (s_ff.cnt >= INIT_C - cnt_t'(1)) begin
          nxt_s.state = ST_USER;
          nxt_s.initDone = 1'b1;
        end
        if (s_ff.state == ST_INIT && s_ff.loadDone && s_ff.cnt == '0) begin
          nxt_s.byteCnt = '0;
        end
      end
      ST_USER: begin
        nxt_s.initDone = 1'b1;
      end
      default: begin
        nxt_s.state = ST_RESET;
      end
    endcase
    // request low wins in every state after power-up
    if (!s_ff.reqS2 && s_ff.state != ST_POWERUP && s_ff.state != ST_RESET) begin
      nxt_s.state = ST_RESET;
      nxt_s.faultOe_n = 1'b0;
      nxt_s.loadDone = 1'b0;
      nxt_s.initDone = 1'b0;
      nxt_s.armed = 1'b0;
      nxt_s.cnt = '0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign link.faultDrv = 1'b0;
  assign link.faultOe_n = s_ff.faultOe_n;
  assign link.loadComplete = s_ff.loadDone;
  assign link.initDone = s_ff.initDone;
  assign cfgByte = s_ff.outByte;
  assign cfgByteValid = s_ff.outValid;
  assign userMode = s_ff.initDone;
endmodule
`default_nettype wire

// ---- ps_cfg_host.sv ----
// Purpose: host end that drives a bitstream into the device over the serial pins
// Assumes: device status pins are asynchronous and synchronised here
// Notes: serial clock is clk_sys divided by PS_SCLK_DIV
`timescale 1ns/1ps
`default_nettype none
`include "ps_cfg_regs.svh"
module ps_cfg_host
  import ps_cfg_pkg::*;
#(
  parameter int CFG_LOW_CYCLES = `PS_CFG_LOW_CYC,
  parameter int CF2CK_CYCLES = `PS_CF2CK_CYC,
  parameter int CHECK_CYCLES = `PS_CHECK_CYC
) (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // configuration pins
  ps_cfg_if.host link,
  // control
  input wire logic start,
  output logic cfgOk,
  output logic cfgFail,
  // bitstream bytes in
  input wire logic [7:0] byteData,
  input wire logic byteLast,
  input wire logic byteValid,
  output logic byteReady
);
  localparam cnt_t LOW_C = cnt_t'(CFG_LOW_CYCLES);
  localparam cnt_t CF2CK_C = cnt_t'(CF2CK_CYCLES);
  localparam cnt_t CHECK_C = cnt_t'(CHECK_CYCLES);
  localparam cnt_t DIV_C = cnt_t'(`PS_SCLK_DIV);
  localparam cnt_t HALF_C = cnt_t'(`PS_SCLK_DIV / 2);

  host_t h_ff, nxt_h;
  logic failNow;

  // fault low while loading means the device wants a restart
  assign failNow = !h_ff.faultS2 && (h_ff.state == H_FETCH || h_ff.state == H_SHIFT ||
                   h_ff.state == H_FLUSH);
  assign byteReady = h_ff.state == H_FETCH && h_ff.faultS2 && !h_ff.last;

  always_comb begin
    nxt_h = h_ff;
    nxt_h.faultS1 = link.cfgFault_n;
    nxt_h.faultS2 = h_ff.faultS1;
    nxt_h.doneS1 = link.loadComplete;
    nxt_h.doneS2 = h_ff.doneS1;
    nxt_h.initS1 = link.initDone;
    nxt_h.initS2 = h_ff.initS1;
    nxt_h.failPulse = 1'b0;
    if (h_ff.cnt != '1) begin
      nxt_h.cnt = h_ff.cnt + cnt_t'(1);
    end
    case (h_ff.state)
      H_IDLE, H_OK: begin
        nxt_h.sclk = 1'b0;
        nxt_h.sbit = 1'b0;
      end
      H_PULSE: begin
        if (h_ff.cnt >= LOW_C - cnt_t'(1)) begin
          nxt_h.reqLow = 1'b0;
          nxt_h.state = H_WAIT;
          nxt_h.cnt = '0;
        end
      end
      H_WAIT: begin
        if (h_ff.cnt >= CF2CK_C - cnt_t'(1) && h_ff.faultS2) begin
          nxt_h.state = H_FETCH;
        end
      end
      H_FETCH: begin
        // with no byte offered the serial clock rests low
        nxt_h.sclk = 1'b0;
        if (h_ff.last) begin
          nxt_h.state = H_FLUSH;
          nxt_h.cnt = '0;
          nxt_h.sbit = 1'b0;
        end else if (byteValid && h_ff.faultS2) begin
          nxt_h.shift = byteData;
          nxt_h.last = byteLast;
          nxt_h.bitCnt = '0;
          nxt_h.sbit = byteData[0];
          nxt_h.state = H_SHIFT;
          nxt_h.cnt = '0;
        end
      end
      H_SHIFT: begin
        nxt_h.sclk = h_ff.cnt >= HALF_C - cnt_t'(1) && h_ff.cnt < DIV_C - cnt_t'(1);
        if (h_ff.cnt >= DIV_C - cnt_t'(1)) begin
          nxt_h.cnt = '0;
          nxt_h.bitCnt = h_ff.bitCnt + 3'h1;
          nxt_h.shift = {1'b0, h_ff.shift[7:1]};
          nxt_h.sbit = h_ff.shift[1];
          if (h_ff.bitCnt == 3'h7) begin
            nxt_h.state = H_FETCH;
          end
        end
      end
      H_FLUSH: begin
        // keep clocking idle bits until the device reports the load done
        nxt_h.sclk = h_ff.cnt[1];
        if (h_ff.doneS2) begin
          nxt_h.state = H_CHECK;
          nxt_h.sclk = 1'b0;
          nxt_h.cnt = '0;
        end else if (h_ff.cnt >= CHECK_C - cnt_t'(1)) begin
          nxt_h.state = H_PULSE;
          nxt_h.reqLow = 1'b1;
          nxt_h.failPulse = 1'b1;
          nxt_h.cnt = '0;
        end
      end
      H_CHECK: begin
        if (h_ff.doneS2 && h_ff.initS2) begin
          nxt_h.state = H_OK;
          nxt_h.ok = 1'b1;
        end else if (h_ff.cnt >= CHECK_C - cnt_t'(1)) begin
          nxt_h.state = H_PULSE;
          nxt_h.reqLow = 1'b1;
          nxt_h.failPulse = 1'b1;
          nxt_h.cnt = '0;
        end
      end
      default: begin
        nxt_h.state = H_IDLE;
      end
    endcase
    if (failNow) begin
      nxt_h.state = H_PULSE;
      nxt_h.reqLow = 1'b1;
      nxt_h.sclk = 1'b0;
      nxt_h.failPulse = 1'b1;
      nxt_h.cnt = '0;
    end
    if (start) begin
      nxt_h.state = H_PULSE;
      nxt_h.reqLow = 1'b1;
      nxt_h.sclk = 1'b0;
      nxt_h.ok = 1'b0;
      nxt_h.cnt = '0;
    end
    if (nxt_h.state == H_PULSE) begin
      nxt_h.last = 1'b0;
      nxt_h.ok = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      h_ff <= '0;
    end else begin
      h_ff <= nxt_h;
    end
  end

  assign link.reconfigRequest_n = ~h_ff.reqLow;
  assign link.serialCfgClk = h_ff.sclk;
  assign link.serialCfgBit = h_ff.sbit;
  assign cfgOk = h_ff.ok;
  assign cfgFail = h_ff.failPulse;
endmodule
`default_nettype wire

// ---- ps_cfg_if.sv ----
// Purpose: pins between the configuration host and the configurable device
// Assumes: fault line is open drain with a pull-up resolved here
// Notes: device drives fault low while faultOe_n is low
`timescale 1ns/1ps
`default_nettype none
interface ps_cfg_if;
  logic reconfigRequest_n;
  logic serialCfgClk;
  logic serialCfgBit;
  logic loadComplete;
  logic initDone;
  logic faultDrv;
  logic faultOe_n;
  logic cfgFault_n;

  assign cfgFault_n = faultOe_n ? 1'b1 : faultDrv;

  modport device (
    input reconfigRequest_n, serialCfgClk, serialCfgBit,
    output loadComplete, initDone, faultDrv, faultOe_n
  );
  modport host (
    output reconfigRequest_n, serialCfgClk, serialCfgBit,
    input loadComplete, initDone, cfgFault_n
  );
endinterface
`default_nettype wire

// ---- ps_cfg_pkg.sv ----
// Purpose: shared types for both ends of the passive serial configuration port
// Assumes: ps_cfg_regs.svh supplies the widths
// Notes: one packed struct per clock domain holds all state
`include "ps_cfg_regs.svh"
package ps_cfg_pkg;
  typedef logic [`PS_CNT_W-1:0] cnt_t;

  typedef enum logic [2:0] {
    ST_POWERUP = 3'h0,
    ST_RESET = 3'h1,
    ST_RELEASE = 3'h2,
    ST_LOAD = 3'h3,
    ST_ERROR = 3'h4,
    ST_INIT = 3'h5,
    ST_USER = 3'h6
  } dev_state_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_PULSE = 3'h1,
    H_WAIT = 3'h2,
    H_FETCH = 3'h3,
    H_SHIFT = 3'h4,
    H_FLUSH = 3'h5,
    H_CHECK = 3'h6,
    H_OK = 3'h7
  } host_state_t;

  typedef struct packed {
    logic reqS1, reqS2;
    logic tglS1, tglS2, tglSeen;
    logic uclkS1, uclkS2, uclkPrev;
    dev_state_t state;
    cnt_t cnt;
    logic [15:0] byteCnt;
    logic [7:0] chk;
    logic armed;
    logic faultOe_n;
    logic loadDone;
    logic initDone;
    logic [7:0] outByte;
    logic outValid;
  } dev_sys_t;

  typedef struct packed {
    logic [7:0] shift;
    logic [2:0] bitCnt;
    logic [7:0] byteData;
    logic byteTgl;
  } dev_link_t;

  typedef struct packed {
    logic faultS1, faultS2;
    logic doneS1, doneS2;
    logic initS1, initS2;
    host_state_t state;
    cnt_t cnt;
    logic [7:0] shift;
    logic [2:0] bitCnt;
    logic last;
    logic reqLow;
    logic sclk;
    logic sbit;
    logic ok;
    logic failPulse;
  } host_t;
endpackage

// ---- ps_cfg_props.sv ----
// Purpose: timing relations on the configuration pins between host and device
// Assumes: one clock domain, clk_sys; pins sampled on its rising edge
// Notes: instantiated beside the interface, no bind
`timescale 1ns/1ps
`default_nettype none
module ps_cfg_props #(
  parameter int CFG_LOW_CYCLES = 800,
  parameter int CF2CK_CYCLES = 800
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // pins
  input wire logic reconfigRequest_n,
  input wire logic serialCfgClk,
  input wire logic serialCfgBit,
  input wire logic loadComplete,
  input wire logic initDone,
  input wire logic cfgFault_n
);
  logic reqPrev_ff;
  logic [15:0] reqLen_ff;
  logic [15:0] faultLow_ff;
  // only the first serial edge of a load must wait for the fault line; later
  // edges may still land in the sync delay after the device flags an error
  logic edgeSeen_ff;

  // run lengths saturate so a long idle spell cannot wrap into a false short one
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reqPrev_ff <= 1'b1;
      reqLen_ff <= 16'h0;
      faultLow_ff <= 16'h0;
      edgeSeen_ff <= 1'b0;
    end else begin
      reqPrev_ff <= reconfigRequest_n;
      if (!reconfigRequest_n) begin
        edgeSeen_ff <= 1'b0;
      end else if (serialCfgClk) begin
        edgeSeen_ff <= 1'b1;
      end
      reqLen_ff <= (reconfigRequest_n != reqPrev_ff) ? 16'h1 :
                   ((reqLen_ff == 16'hffff) ? reqLen_ff : reqLen_ff + 16'h1);
      faultLow_ff <= cfgFault_n ? 16'h0 : ((faultLow_ff == 16'hffff) ? faultLow_ff : faultLow_ff + 16'h1);
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence bothLow_s;
    !cfgFault_n && !loadComplete;
  endsequence
  sequence userEntry_s;
    ##[8:520] initDone;
  endsequence

  req_drop_a: assert property ($fell(reconfigRequest_n) |-> ##[1:16] bothLow_s)
    else $error("fault or load complete not low after request fell");
  fault_release_a: assert property ($rose(reconfigRequest_n) |-> ##[1:800] cfgFault_n)
    else $error("fault not released after request rose");
  fault_width_a: assert property ($rose(cfgFault_n) |-> faultLow_ff >= 16'd198)
    else $error("fault low pulse too short");
  done_cause_a: assert property ($rose(loadComplete) |-> reconfigRequest_n && cfgFault_n)
    else $error("load complete rose without a live load");
  user_entry_a: assert property ($rose(loadComplete) |-> userEntry_s)
    else $error("user mode late after load complete");
  done_hold_a: assert property (loadComplete && reconfigRequest_n |=> loadComplete)
    else $error("load complete dropped while request high");
  pins_parked_a: assert property (initDone && reconfigRequest_n |-> $stable(serialCfgClk) && $stable(serialCfgBit))
    else $error("serial pins move in user mode");
  req_pulse_a: assert property ($rose(reconfigRequest_n) |-> reqLen_ff >= 16'(CFG_LOW_CYCLES - 1))
    else $error("request low pulse too short");
  first_clk_a: assert property ($rose(serialCfgClk) && !edgeSeen_ff |-> cfgFault_n && reconfigRequest_n &&
                                reqLen_ff >= 16'(CF2CK_CYCLES - 1))
    else $error("serial clock edge too early");
  sclk_rate_a: assert property ($fell(serialCfgClk) |=> !serialCfgClk)
    else $error("serial clock low phase too short");
  bit_setup_a: assert property ($changed(serialCfgBit) |-> !serialCfgClk)
    else $error("serial data changed while clock high");
endmodule
`default_nettype wire

// ---- ps_cfg_regs.svh ----
// Purpose: timing counts and frame layout constants for the passive serial configuration port
// Assumes: system clock period below; all cycle counts except PS_SCLK_DIV and the user clock period counts derived from it
// Notes: definitions only
`ifndef PS_CFG_REGS_SVH
`define PS_CFG_REGS_SVH

`define PS_SYS_PERIOD_NS 50
`define PS_CNT_W 22
// least times round up, longest times round down
`define PS_US_CYC_UP(us) ((((us) * 1000) + `PS_SYS_PERIOD_NS - 1) / `PS_SYS_PERIOD_NS)
`define PS_US_CYC_DN(us) (((us) * 1000) / `PS_SYS_PERIOD_NS)

`define PS_T_POWERUP_MS 100
`define PS_POWERUP_CYC ((`PS_T_POWERUP_MS * 1000000) / `PS_SYS_PERIOD_NS)
`define PS_T_STATUS_MIN_US 10
`define PS_STATUS_MIN_CYC `PS_US_CYC_UP(`PS_T_STATUS_MIN_US)
`define PS_T_RETRY_US 30
`define PS_RETRY_CYC `PS_US_CYC_UP(`PS_T_RETRY_US)
`define PS_T_CD2UM_US 20
`define PS_INIT_CYC `PS_US_CYC_DN(`PS_T_CD2UM_US)
`define PS_USER_INIT_PERIODS 140
`define PS_USER_CFG_PERIODS 270
`define PS_T_CFG_MIN_US 40
`define PS_CFG_LOW_CYC `PS_US_CYC_UP(`PS_T_CFG_MIN_US)
`define PS_T_CF2CK_US 40
`define PS_CF2CK_CYC `PS_US_CYC_UP(`PS_T_CF2CK_US)
`define PS_T_CHECK_US 60
`define PS_CHECK_CYC `PS_US_CYC_UP(`PS_T_CHECK_US)

// serial clock divider: clk_sys cycles per serial bit, half low then half high
`define PS_SCLK_DIV 4
// frame: sync byte, payload, xor check byte over all earlier bytes
`define PS_SYNC_BYTE 8'ha5
`define PS_FRAME_BYTES 16

`endif

// ---- tb_passive_serial_config_port.sv ----
// Purpose: host and device ends joined, frames good and bad in every option mode
// Assumes: host clock-delay and check counts shortened, request low pulse lengthened; device power-up hold shortened
// Notes: outcomes are noted in a queue by the driver and checked by a monitor
`timescale 1ns/1ps
`default_nettype none
`include "ps_cfg_regs.svh"
module tb_passive_serial_config_port;
  import ps_cfg_pkg::*;
  localparam int LOW_CYC = 900;
  localparam int CK_CYC = 40;
  logic clk_sys, arst_n, userInitClk, autoRetry, useUserClk, start;
  logic [7:0] byteData;
  logic byteLast, byteValid, byteReady, cfgOk, cfgFail, userMode, okPrev, failSticky, expNote;
  logic expQ[$];
  logic [7:0] payQ[$];
  logic [7:0] cfgByte;
  logic cfgByteValid;
  int failures, checksDone;

  ps_cfg_if link();
  ps_cfg_device #(.POWERUP_CYCLES(300)) ps_cfg_device_inst (.clk_sys(clk_sys), .arst_n(arst_n), .link(link),
    .autoRetry(autoRetry), .useUserClk(useUserClk), .userInitClk(userInitClk), .cfgByte(cfgByte),
    .cfgByteValid(cfgByteValid),
    .userMode(userMode));
  ps_cfg_host #(.CFG_LOW_CYCLES(LOW_CYC), .CF2CK_CYCLES(CK_CYC), .CHECK_CYCLES(600)) ps_cfg_host_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .link(link), .start(start), .cfgOk(cfgOk), .cfgFail(cfgFail),
    .byteData(byteData), .byteLast(byteLast), .byteValid(byteValid), .byteReady(byteReady));
  ps_cfg_props #(.CFG_LOW_CYCLES(LOW_CYC), .CF2CK_CYCLES(CK_CYC)) ps_cfg_props_inst (.clk_sys(clk_sys),
    .arst_n(arst_n), .reconfigRequest_n(link.reconfigRequest_n), .serialCfgClk(link.serialCfgClk),
    .serialCfgBit(link.serialCfgBit), .loadComplete(link.loadComplete), .initDone(link.initDone),
    .cfgFault_n(link.cfgFault_n));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // user init clock runs free at 160 ns, unrelated in phase to clk_sys
  initial begin
    userInitClk = 1'b0;
    #13;
    forever #80 userInitClk = ~userInitClk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checksDone++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (failures == 0 && checksDone > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // monitor: every finished attempt, good or refused, consumes one note
  always @(posedge clk_sys) begin
    okPrev <= cfgOk;
    if (cfgByteValid === 1'b1)
      check(cfgByte, (payQ.size() > 0) ? payQ.pop_front() : ~cfgByte);
    if (cfgFail === 1'b1)
      failSticky = 1'b1;
    if (cfgFail === 1'b1 || (cfgOk === 1'b1 && okPrev !== 1'b1)) begin
      expNote = (expQ.size() > 0) ? expQ.pop_front() : ~cfgOk;
      check({7'h0, cfgOk}, {7'h0, expNote});
      if (expNote === 1'b1) begin
        check({7'h0, link.loadComplete}, 8'h1);
        check({7'h0, userMode}, 8'h1);
      end
    end
  end

  // gaps between bytes stop the serial clock mid-frame
  task automatic send_frame(input int badAt);
    logic [7:0] b[16];
    int n;
    b[0] = `PS_SYNC_BYTE;
    b[15] = 8'h0;
    for (int i = 1; i < 15; i++)
      b[i] = 8'($urandom);
    for (int i = 0; i < 15; i++)
      b[15] ^= b[i];
    if (badAt < 16)
      b[badAt] ^= 8'h10;
    failSticky = 1'b0;
    for (int i = 0; i < `PS_FRAME_BYTES && !failSticky; i++) begin
      repeat ($urandom_range(0, 6)) @(posedge clk_sys);
      @(posedge clk_sys);
      byteValid <= 1'b1;
      byteData <= b[i];
      byteLast <= (i == 15);
      // payload bytes surface only when the sync byte was good
      if (badAt != 0 && i > 0 && i < 15)
        payQ.push_back(b[i]);
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (byteReady !== 1'b1 && !failSticky && n < 4000);
      byteValid <= 1'b0;
      byteLast <= 1'b0;
      if (n >= 4000)
        check(8'h0, 8'h1);
    end
  endtask

  task automatic wait_outcome();
    int n;
    n = 0;
    while (expQ.size() > 0 && n < 20000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 20000)
      check(8'h0, 8'h1);
  endtask

  initial begin
    failures = 0;
    checksDone = 0;
    arst_n = 1'b0;
    autoRetry = 1'b0;
    useUserClk = 1'b0;
    start = 1'b0;
    byteData = 8'h0;
    byteLast = 1'b0;
    byteValid = 1'b0;
    failSticky = 1'b0;
    okPrev = 1'b0;
    void'($urandom(37));
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (250) @(posedge clk_sys);
    check({7'h0, link.cfgFault_n}, 8'h0);
    check({7'h0, link.loadComplete}, 8'h0);
    repeat (100) @(posedge clk_sys);
    // every option mode: a corrupt frame is refused, then a clean one loads
    for (int m = 0; m < 4; m++) begin
      autoRetry <= m[0];
      useUserClk <= m[1];
      @(posedge clk_sys);
      start <= 1'b1;
      @(posedge clk_sys);
      start <= 1'b0;
      expQ.push_back(1'b0);
      send_frame(m[0] ? 15 : 0);
      wait_outcome();
      expQ.push_back(1'b1);
      send_frame(16);
      wait_outcome();
      check(8'(payQ.size()), 8'h0);
    end
    wrap_up();
  end

  initial begin
    #4000000;
    failures++;
    wrap_up();
  end
endmodule
`default_nettype wire
